/* verilog/ssup_top.sv */
// Safety I/O stop supervisor with APB configuration and status
`timescale 1ns/1ns
//
// Contract
// RULE1 - Each safety input and output exists on two independent channels.
// RULE2 - Accept eight redundant safety input functions.
// RULE3 - Drive eight redundant safety status outputs.
// RULE4 - Emergency stop: category 1, program stop, power off, manual reset.
// RULE5 - Safeguard stop: category 2, pause, power kept, configurable reset.
// RULE6 - Detect any safety input change within 100 ms.
// RULE7 - Emergency stops: power off within 1200 ms, respond within 1300 ms.
// RULE8 - Other safety inputs take effect within 1200 ms.
// RULE9 - Status outputs follow their condition within 1000 ms.
// RULE10 - Automatic reset resumes motion once the safeguard input clears.
// RULE11 - Manual reset holds the stop until the reset input is given.
// RULE12 - Too frequent safeguard stops may raise a system error.
// RULE13 - A setting selects automatic or manual safeguard reset.
// RULE14 - Reduced mode input selects the reduced speed limits.
// RULE15 - In verification mode move only while enabling device is valid.
// RULE16 - System stop input causes a category 1 stop.
// RULE17 - Not-stopping output shows deceleration after a stop request.
// RULE18 - Persistent channel disagreement raises error and a safe stop.
// RULE19 - Normally-closed estop output is the complement of normally-open.
module ssup_top
  import ssup_pkg::*;
#(
  parameter int unsigned FILT_P = FILT_CYC,
  parameter int unsigned DISC_P = DETECT_CYC,
  parameter int unsigned POWER_OFF_P = POWER_OFF_CYC,
  parameter int unsigned STOP2_P = STOP2_CYC,
  parameter int unsigned RATE_WIN_P = RATE_WIN_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ssup_in_t safety_in_a,
  input wire ssup_in_t safety_in_b,
  input wire logic motion_active,
  output ssup_out_t safety_out_a,
  output ssup_out_t safety_out_b,
  output logic drive_power_en,
  output logic program_run,
  output logic program_pause,
  output logic program_stop,
  output logic [15:0] joint_speed_lim,
  output logic [15:0] tcp_speed_lim
);
  ssup_in_t filt;
  logic [IN_W-1:0] filt_raw, mismatch;
  logic rate_err;
  logic guard_rise;
  ssup_state_t state_q, state_d;
  ssup_cnt_t tmr_q;
  logic auto_q, guard_lat_q, reset_prev_q, guard_prev_q;
  logic [31:0] norm_lim_q, red_lim_q;
  logic [FAULT_W-1:0] fault_q, fault_set;
  logic power_q;
  ssup_out_t out_d;

  function automatic logic is_c1(input ssup_state_t s);
    is_c1 = (s == ST_C1_DECEL) || (s == ST_C1_OFF);
  endfunction

  function automatic logic is_decel(input ssup_state_t s);
    is_decel = (s == ST_C1_DECEL) || (s == ST_C2_DECEL);
  endfunction

  // Both channels of all eight inputs are filtered and compared
  ssup_dual_in #(.FILT(FILT_P), .DISC(DISC_P)) u_in ( // see RULE1
    .clock(clock),
    .rst(rst),
    .chan_a(safety_in_a), // see RULE2
    .chan_b(safety_in_b),
    .value_q(filt_raw),
    .mismatch_q(mismatch)
  );
  assign filt = ssup_in_t'(filt_raw);

  ssup_rate_mon #(.WIN(RATE_WIN_P)) u_rate (
    .clock(clock),
    .rst(rst),
    .stop_event(guard_rise),
    .rate_err_q(rate_err)
  );

  // APB decode; writes land on the edge that completes the transfer
  wire apb_acc = psel && penable && !pready;
  wire apb_done = psel && penable && pready;
  wire apb_wr = apb_done && pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_norm = paddr == OFF_NORM_LIM;
  wire hit_red = paddr == OFF_RED_LIM;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_fault = paddr == OFF_FAULT;
  wire hit_any = hit_ctrl | hit_norm | hit_red | hit_stat | hit_fault;
  wire wr_ctrl = apb_wr && hit_ctrl;
  wire estop_reset_cmd = wr_ctrl && pwdata[CTRL_RESET_BIT];
  wire wr_fault = apb_wr && hit_fault;

  // Stop demands
  wire fault_any = |fault_q;
  wire estop_req = filt.ext_estop_in | filt.system_stop_in | fault_any;
  wire guard_req = filt.safeguard_stop_in;
  wire verify_hold = filt.operating_mode_in & ~filt.enabling_device_in;
  assign guard_rise = guard_req & ~guard_prev_q;
  wire reset_rise = filt.safeguard_reset_in & ~reset_prev_q;
  wire c2_release = !guard_req && !verify_hold &&
                    (!guard_lat_q || auto_q || reset_rise);
  wire c1_done = !motion_active || tmr_q >= ssup_cnt_t'(POWER_OFF_P - 1);
  wire c2_done = !motion_active || tmr_q >= ssup_cnt_t'(STOP2_P - 1);

  // Next state of the stop sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (estop_req) begin
          state_d = ST_C1_DECEL; // see RULE4 RULE16 RULE18
        end else if (guard_req || verify_hold) begin
          state_d = ST_C2_DECEL; // see RULE5 RULE15
        end
      end
      ST_C2_DECEL: begin
        if (estop_req) begin
          state_d = ST_C1_DECEL;
        end else if (c2_done) begin
          state_d = ST_C2_HOLD; // see RULE8
        end
      end
      ST_C2_HOLD: begin
        if (estop_req) begin
          state_d = ST_C1_DECEL;
        end else if (c2_release) begin
          state_d = ST_RUN; // see RULE10 RULE11 RULE13
        end
      end
      ST_C1_DECEL: begin
        if (c1_done) begin
          state_d = ST_C1_OFF; // see RULE7
        end
      end
      ST_C1_OFF: begin
        if (estop_reset_cmd && !estop_req) begin
          state_d = ST_RUN; // see RULE4
        end
      end
      default: state_d = ST_C1_OFF;
    endcase
  end

  // Sequencer state and the stop timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_C1_OFF;
      tmr_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= (state_d != state_q) ? '0 : cnt_inc(tmr_q);
    end
  end

  // Remember why the category 2 stop was taken and sample edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      guard_lat_q <= 1'b0;
      guard_prev_q <= 1'b0;
      reset_prev_q <= 1'b0;
    end else begin
      guard_prev_q <= guard_req;
      reset_prev_q <= filt.safeguard_reset_in;
      if (state_q == ST_RUN) begin
        guard_lat_q <= guard_req;
      end else if (state_q == ST_C2_DECEL && guard_req) begin
        guard_lat_q <= 1'b1;
      end
    end
  end

  // Fault flags: a new event beats a clear in the same cycle
  assign fault_set = {rate_err, mismatch};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_set | (fault_q &
                 ~(wr_fault ? pwdata[FAULT_W-1:0] : '0)); // see RULE18
    end
  end

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      auto_q <= CTRL_AUTO_RST;
      norm_lim_q <= NORM_LIM_RST;
      red_lim_q <= RED_LIM_RST;
    end else begin
      if (wr_ctrl) begin
        auto_q <= pwdata[CTRL_AUTO_BIT]; // see RULE13
      end
      if (apb_wr && hit_norm) begin
        norm_lim_q <= pwdata;
      end
      if (apb_wr && hit_red) begin
        red_lim_q <= pwdata;
      end
    end
  end

  // Status word: power, program states, fault, filtered inputs
  wire [31:0] status_w = {16'h0000, filt_raw, 2'b00, fault_any,
                          is_decel(state_q), program_stop,
                          program_pause, program_run, power_q};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, 1'b0, auto_q} :
                       hit_norm ? norm_lim_q :
                       hit_red ? red_lim_q :
                       hit_stat ? status_w :
                       hit_fault ? {23'h00_0000, fault_q} : 32'h0000_0000;

  // One wait state; unmapped addresses answer with an error
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc && !hit_any;
      if (apb_acc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Output values, both channels from separate flops
  always_comb begin
    out_d.estop_no_out = is_c1(state_q);
    out_d.estop_nc_out = ~is_c1(state_q); // see RULE19
    out_d.moving_out = (state_q == ST_RUN) && motion_active;
    out_d.not_stopping_out = is_decel(state_q) && motion_active; // see RULE17
    out_d.reduced_speed_out = filt.reduced_speed_in;
    out_d.normal_speed_out = ~filt.reduced_speed_in;
    out_d.system_fault_out = fault_any;
    out_d.system_running_out = power_q && !fault_any;
  end

  // Outputs settle one cycle after the state, far inside 1000 ms
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      safety_out_a <= '{estop_nc_out: 1'b1, default: 1'b0};
      safety_out_b <= '{estop_nc_out: 1'b1, default: 1'b0};
    end else begin
      safety_out_a <= out_d; // see RULE3 RULE9
      safety_out_b <= out_d; // see RULE1
    end
  end

  // Drive power and program state follow the sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_q <= 1'b0;
      drive_power_en <= 1'b0;
      program_run <= 1'b0;
      program_pause <= 1'b0;
      program_stop <= 1'b1;
      joint_speed_lim <= 16'h0000;
      tcp_speed_lim <= 16'h0000;
    end else begin
      power_q <= state_d != ST_C1_OFF; // see RULE4 RULE5
      drive_power_en <= state_d != ST_C1_OFF;
      program_run <= state_d == ST_RUN;
      program_pause <= state_d == ST_C2_DECEL || state_d == ST_C2_HOLD;
      program_stop <= is_c1(state_d);
      // Reduced input swaps the limit set; see RULE14
      joint_speed_lim <= filt.reduced_speed_in ? red_lim_q[15:0]
                                               : norm_lim_q[15:0];
      tcp_speed_lim <= filt.reduced_speed_in ? red_lim_q[31:16]
                                             : norm_lim_q[31:16];
    end
  end

  // Checks on the stop sequencer and its outputs
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_estop_enter: assert property ( // see RULE4
    state_q == ST_RUN && filt.ext_estop_in |=> state_q == ST_C1_DECEL)
    else $error("estop did not start a category 1 stop");
  a_sysstop_enter: assert property ( // see RULE16
    !is_c1(state_q) && filt.system_stop_in
    |=> state_q == ST_C1_DECEL ##1 safety_out_a.estop_no_out)
    else $error("system stop did not reach estop output");
  a_power_off_bound: assert property ( // see RULE7
    state_q == ST_C1_DECEL |-> tmr_q < ssup_cnt_t'(POWER_OFF_P))
    else $error("power off deadline exceeded");
  a_c2_keeps_power: assert property ( // see RULE5
    state_q == ST_C2_HOLD |=> drive_power_en)
    else $error("drive power lost in category 2 stop");
  a_manual_hold: assert property ( // see RULE11
    state_q == ST_C2_HOLD && !auto_q && guard_lat_q && !reset_rise
    && !estop_req |=> state_q == ST_C2_HOLD)
    else $error("manual reset stop left without reset");
  a_auto_resume: assert property ( // see RULE10
    state_q == ST_C2_HOLD && auto_q && !guard_req && !verify_hold
    && !estop_req |=> state_q == ST_RUN && program_run)
    else $error("auto reset did not resume");
  a_verify_pause: assert property ( // see RULE15
    state_q == ST_RUN && verify_hold && !estop_req
    |=> state_q == ST_C2_DECEL)
    else $error("verification pause not taken");
  a_fault_stop: assert property ( // see RULE18
    $rose(fault_any) |-> ##[1:2] is_c1(state_q) ##1
    safety_out_a.system_fault_out)
    else $error("fault did not force a safe stop");
  a_nc_complement: assert property ( // see RULE19
    safety_out_b.estop_nc_out != safety_out_a.estop_no_out)
    else $error("estop contacts not complementary");
  a_chan_equal: assert property ( // see RULE1
    safety_out_a == safety_out_b)
    else $error("output channels differ");
  a_not_stop_flag: assert property ( // see RULE17
    is_decel(state_q) && motion_active |=> safety_out_a.not_stopping_out)
    else $error("not stopping output missing");
  a_rate_fault: assert property ( // see RULE12
    rate_err |=> fault_q[FAULT_RATE_BIT])
    else $error("rate error not recorded");

  c_estop_cycle: cover property (
    state_q == ST_C1_OFF ##1 state_q == ST_RUN);
  c_auto_resume: cover property (
    state_q == ST_C2_HOLD && auto_q ##1 state_q == ST_RUN);
  c_manual_reset: cover property (
    state_q == ST_C2_HOLD && !auto_q && reset_rise ##1 state_q == ST_RUN);
endmodule

/* verilog/ssup_pkg.sv */
// Shared constants, carriers and states of the safety I/O stop supervisor
package ssup_pkg;

  // Clock rate and documented worst-case times
  localparam int unsigned CLK_KHZ = 50_000;
  localparam int unsigned DETECT_MS = 100;
  localparam int unsigned POWER_OFF_MS = 1200;
  localparam int unsigned RESP_C1_MS = 1300;
  localparam int unsigned RESP_C2_MS = 1200;
  localparam int unsigned OUTPUT_MS = 1000;
  localparam int unsigned RATE_WIN_MS = 1000;

  // Cycle counts; longest times round down
  localparam int unsigned DETECT_CYC = DETECT_MS * CLK_KHZ;
  localparam int unsigned FILT_CYC = DETECT_CYC / 2;
  localparam int unsigned POWER_OFF_CYC = POWER_OFF_MS * CLK_KHZ;
  localparam int unsigned STOP2_CYC = RESP_C2_MS * CLK_KHZ;
  localparam int unsigned RATE_WIN_CYC = RATE_WIN_MS * CLK_KHZ;
  localparam int unsigned RATE_MAX = 4;

  // Counters cover the longest count (60 M cycles)
  localparam int unsigned CNT_W = 27;
  typedef logic [CNT_W-1:0] ssup_cnt_t;

  // Register map, byte addresses on a 32-bit APB
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NORM_LIM = 8'h04;
  localparam logic [7:0] OFF_RED_LIM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_FAULT = 8'h10;
  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam int unsigned CTRL_RESET_BIT = 1;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic [31:0] NORM_LIM_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] RED_LIM_RST = 32'h0100_0100;
  localparam int unsigned FAULT_RATE_BIT = 8;
  localparam int unsigned FAULT_W = 9;
  localparam int unsigned IN_W = 8;

  // Eight safety inputs, high means the function is demanded
  typedef struct packed {
    logic system_stop_in;
    logic force_ctrl_enable_in;
    logic operating_mode_in;
    logic enabling_device_in;
    logic safeguard_reset_in;
    logic reduced_speed_in;
    logic safeguard_stop_in;
    logic ext_estop_in;
  } ssup_in_t;

  // Eight safety outputs of one channel
  typedef struct packed {
    logic system_running_out;
    logic estop_nc_out;
    logic system_fault_out;
    logic normal_speed_out;
    logic reduced_speed_out;
    logic not_stopping_out;
    logic moving_out;
    logic estop_no_out;
  } ssup_out_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_C2_DECEL, ST_C2_HOLD, ST_C1_DECEL, ST_C1_OFF
  } ssup_state_t;

  // Saturating counter step
  function automatic ssup_cnt_t cnt_inc(input ssup_cnt_t c);
    cnt_inc = (&c) ? c : c + ssup_cnt_t'(1);
  endfunction

endpackage

/* verilog/ssup_dual_in.sv */
// Two-channel safety input synchroniser, filter and discrepancy check
`timescale 1ns/1ns
module ssup_dual_in
  import ssup_pkg::*;
#(
  parameter int unsigned FILT = FILT_CYC,
  parameter int unsigned DISC = DETECT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [IN_W-1:0] chan_a,
  input wire logic [IN_W-1:0] chan_b,
  output logic [IN_W-1:0] value_q,
  output logic [IN_W-1:0] mismatch_q
);
  logic [IN_W-1:0] a1_q, a2_q, b1_q, b2_q;

  // Pins are asynchronous, two flops per channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a1_q <= '0;
      a2_q <= '0;
      b1_q <= '0;
      b2_q <= '0;
    end else begin
      a1_q <= chan_a;
      a2_q <= a1_q;
      b1_q <= chan_b;
      b2_q <= b1_q;
    end
  end

  // Per bit: agreeing channels must hold a new level FILT cycles
  for (genvar i = 0; i < IN_W; i++) begin : g_bit
    ssup_cnt_t filt_q, disc_q;
    wire agree = a2_q[i] == b2_q[i];
    wire change = agree && (a2_q[i] != value_q[i]);
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        filt_q <= '0;
        disc_q <= '0;
        value_q[i] <= 1'b0;
        mismatch_q[i] <= 1'b0;
      end else begin
        filt_q <= change ? cnt_inc(filt_q) : '0;
        disc_q <= agree ? '0 : cnt_inc(disc_q);
        if (change && filt_q >= ssup_cnt_t'(FILT - 1)) begin // see RULE6
          value_q[i] <= a2_q[i];
        end
        // Persistent disagreement is a fault; see RULE18
        mismatch_q[i] <= !agree && disc_q >= ssup_cnt_t'(DISC - 1);
      end
    end
  end
endmodule

/* verilog/ssup_rate_mon.sv */
// Counts safeguard stops per window and flags too high a rate
`timescale 1ns/1ns
module ssup_rate_mon
  import ssup_pkg::*;
#(
  parameter int unsigned WIN = RATE_WIN_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic stop_event,
  output logic rate_err_q
);
  ssup_cnt_t win_q;
  logic [3:0] num_q;
  wire win_end = win_q >= ssup_cnt_t'(WIN - 1);

  // Fixed windows keep the logic small at the cost of edge effects
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      win_q <= '0;
      num_q <= '0;
      rate_err_q <= 1'b0;
    end else begin
      win_q <= win_end ? '0 : cnt_inc(win_q);
      if (win_end) begin
        num_q <= '0;
      end else if (stop_event && !(&num_q)) begin
        num_q <= num_q + 4'h1;
      end
      rate_err_q <= num_q > 4'(RATE_MAX); // see RULE12
    end
  end
endmodule

/* dv/ssup_ext_model.sv */
// Model of the external safety devices and of the moving robot
`timescale 1ns/1ns
module ssup_ext_model
  import ssup_pkg::*;
#(
  parameter int unsigned DECEL = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire ssup_in_t demand,
  input wire ssup_in_t break_b,
  input wire logic program_run,
  output ssup_in_t safety_in_a,
  output ssup_in_t safety_in_b,
  output logic motion_active
);
  int unsigned decel_q;

  // Both channels carry the demand; break_b spoils channel B alone
  assign safety_in_a = demand;
  assign safety_in_b = ssup_in_t'(demand ^ break_b);

  // Robot coasts DECEL cycles after the program stops, so decel is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      decel_q <= 0;
    end else if (program_run) begin
      decel_q <= DECEL;
    end else if (decel_q != 0) begin
      decel_q <= decel_q - 1;
    end
  end
  assign motion_active = (decel_q != 0);
endmodule

/* dv/tb.sv */
// Self-checking testbench of the safety I/O stop supervisor
`timescale 1ns/1ns
module tb;
  import ssup_pkg::*;
  // Short counts keep the run brief; waits scale from them
  localparam int unsigned FP = 4;
  localparam int unsigned PW = 50;
  typedef struct packed {
    logic [7:0] dem;
    logic [3:0] exp;
    logic red;
  } ssup_row_t;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic motion_active, drive_power_en;
  logic program_run, program_pause, program_stop;
  logic [15:0] joint_speed_lim, tcp_speed_lim;
  ssup_in_t safety_in_a, safety_in_b, demand, break_b;
  ssup_out_t safety_out_a, safety_out_b;
  int errors, n_compared;
  // Demand on the inputs, then {run, pause, stop, power} and reduced
  ssup_row_t rows [8] = '{
    '{8'h00, 4'h9, 1'b0},
    '{8'h01, 4'h2, 1'b0},
    '{8'h02, 4'h5, 1'b0},
    '{8'h04, 4'h9, 1'b1},
    '{8'h20, 4'h5, 1'b0},
    '{8'h30, 4'h9, 1'b0},
    '{8'h40, 4'h9, 1'b0},
    '{8'h80, 4'h2, 1'b0}};
  // Registers readable after reset and their reset values
  logic [7:0] ra [3] = '{OFF_CTRL, OFF_NORM_LIM, OFF_RED_LIM};
  logic [31:0] rv [3] = '{32'h0000_0001, NORM_LIM_RST, RED_LIM_RST};

  ssup_top #(.FILT_P(FP), .DISC_P(16), .POWER_OFF_P(PW), .STOP2_P(PW),
    .RATE_WIN_P(200)) u_ssup_top (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safety_in_a(safety_in_a), .safety_in_b(safety_in_b),
    .motion_active(motion_active), .safety_out_a(safety_out_a),
    .safety_out_b(safety_out_b), .drive_power_en(drive_power_en),
    .program_run(program_run), .program_pause(program_pause),
    .program_stop(program_stop), .joint_speed_lim(joint_speed_lim),
    .tcp_speed_lim(tcp_speed_lim));

  ssup_ext_model u_ssup_ext_model (.clock(clock), .rst(rst),
    .demand(demand), .break_b(break_b), .program_run(program_run),
    .safety_in_a(safety_in_a), .safety_in_b(safety_in_b),
    .motion_active(motion_active));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic final_report();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input logic [3:0] exp);
    chk_word({28'h0, program_run, program_pause, program_stop,
      drive_power_en}, {28'h0, exp});
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drive a demand, let n cycles pass, land on a falling edge
  task automatic set_in(input logic [7:0] v, input int unsigned n);
    @(posedge clock);
    demand <= ssup_in_t'(v);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // Channels stay identical and the two estop outputs complementary
  always @(negedge clock) begin
    if (!rst) begin
      chk_word({24'h0, safety_out_a}, {24'h0, safety_out_b});
      chk_bit(safety_out_a.estop_nc_out,
        ~safety_out_a.estop_no_out);
    end
  end

  // Watchdog, far beyond the expected length of the run
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    demand = '0;
    break_b = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk_state(4'h2);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk_word(rd, rv[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk_bit(er, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    set_in(8'h00, 5);
    chk_state(4'h9);
    // Status shows power on and program running, inputs idle
    apb(1'b0, OFF_STATUS, 32'h0);
    chk_word(rd, 32'h0000_0003);
    // Table of demands, each followed by recovery to running
    foreach (rows[i]) begin
      set_in(rows[i].dem, PW + FP + 20);
      chk_state(rows[i].exp);
      chk_bit(safety_out_a.estop_no_out, rows[i].exp[1]);
      chk_bit(safety_out_a.system_running_out, rows[i].exp[0]);
      chk_bit(safety_out_a.moving_out, rows[i].exp[3]);
      chk_bit(safety_out_a.reduced_speed_out, rows[i].red);
      chk_bit(safety_out_a.normal_speed_out, !rows[i].red);
      chk_word({16'h0, joint_speed_lim}, {16'h0, rows[i].red ?
        RED_LIM_RST[15:0] : NORM_LIM_RST[15:0]});
      chk_word({16'h0, tcp_speed_lim}, {16'h0, rows[i].red ?
        RED_LIM_RST[31:16] : NORM_LIM_RST[31:16]});
      set_in(8'h00, FP + 10);
      apb(1'b1, OFF_CTRL, 32'h0000_0003);
      set_in(8'h00, FP + 10);
    end
    // Deceleration is visible before the drive power drops
    set_in(8'h01, FP + 7);
    chk_bit(safety_out_a.not_stopping_out, 1'b1);
    chk_bit(drive_power_en, 1'b1);
    set_in(8'h01, PW);
    chk_bit(safety_out_a.not_stopping_out, 1'b0);
    chk_bit(drive_power_en, 1'b0);
    set_in(8'h00, FP + 10);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    // Manual reset holds the pause until the reset input pulses
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk_word(rd, 32'h0000_0000);
    set_in(8'h02, PW + FP + 20);
    set_in(8'h00, FP + 20);
    chk_state(4'h5);
    set_in(8'h08, FP + 10);
    set_in(8'h00, FP + 10);
    chk_state(4'h9);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    // Channel B disagrees long enough to count as a fault
    @(posedge clock);
    break_b <= ssup_in_t'(8'h02);
    set_in(8'h00, PW + FP + 40);
    chk_bit(safety_out_a.system_fault_out, 1'b1);
    chk_state(4'h2);
    apb(1'b0, OFF_FAULT, 32'h0);
    chk_word(rd & 32'h0000_0002, 32'h0000_0002);
    break_b <= '0;
    set_in(8'h00, FP + 10);
    apb(1'b1, OFF_FAULT, 32'h0000_01FF);
    apb(1'b0, OFF_FAULT, 32'h0);
    chk_word(rd, 32'h0000_0000);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    set_in(8'h00, 5);
    chk_state(4'h9);
    // Ten safeguard stops inside two rate windows trip the rate flag
    for (int i = 0; i < 10; i++) begin
      set_in(8'h02, 10);
      set_in(8'h00, 10);
    end
    apb(1'b0, OFF_FAULT, 32'h0);
    chk_word(rd & 32'h0000_0100, 32'h0000_0100);
    final_report();
  end
endmodule
